// ### hdl/drs_pkg.sv
// Package of register map, field layout, reset values and state types for the drive run sequencer.
package drs_pkg;

    // ----------------------------------------------------------------
    // Register offsets (byte addresses on the APB bus)
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_AUTO_START = 8'h00;
    localparam logic [7:0] ADDR_SEQ_MODE = 8'h04;
    localparam logic [7:0] ADDR_CONFIG = 8'h08;
    localparam logic [7:0] ADDR_SEQ_SERIAL = 8'h0c;
    localparam logic [7:0] ADDR_TERM_ASSIGN = 8'h10;
    localparam logic [7:0] ADDR_STATUS = 8'h14;

    // ----------------------------------------------------------------
    // Auto-start selector codes and reset value
    // ----------------------------------------------------------------
    localparam logic [1:0] AUTOSTART_OFF = 2'h0;
    localparam logic [1:0] AUTOSTART_ALWAYS = 2'h1;
    localparam logic [1:0] AUTOSTART_POWERDOWN_DEPENDENT = 2'h2;
    localparam logic [1:0] AUTO_START_RESET = 2'h0;

    // ----------------------------------------------------------------
    // Sequencing modes, reset value and keypad reference code
    // ----------------------------------------------------------------
    localparam logic [2:0] SEQ_MODE_PUSHBUTTON = 3'h0;
    localparam logic [2:0] SEQ_MODE_LEGACY = 3'h1;
    localparam logic [2:0] SEQ_MODE_MAX = 3'h4;
    localparam logic [2:0] SEQ_MODE_RESET = 3'h2;
    localparam logic [2:0] KEYPAD_REF_SEL = 3'h4;
    localparam logic [2:0] KEYPAD_REF_RESET = 3'h0;

    // ----------------------------------------------------------------
    // Field positions and reset values
    // ----------------------------------------------------------------
    localparam int CFG_KEY_RUN_EN = 0;
    localparam int CFG_KEY_STOP_EN = 1;
    localparam int CFG_KEY_DIR_EN = 2;
    localparam int CFG_OUT_STAGE_EN = 3;
    localparam int CFG_KP_REF_LSB = 4;
    localparam int SEQ_BIT_RUN = 0;
    localparam int SEQ_BIT_JOG = 1;
    localparam int SEQ_BIT_DIR = 2;
    localparam int SEQ_BIT_DRIVE_EN = 4;
    localparam int ST_REV_POS = 4;
    localparam int ST_REC_POS = 5;
    localparam int ST_TRIP_POS = 6;
    localparam logic OUT_STAGE_EN_RESET = 1'b1;
    localparam logic [4:0] SEQ_SERIAL_RESET = 5'h00;
    localparam logic [4:0] TERM_ASSIGN_RESET = 5'h00;

    // ----------------------------------------------------------------
    // Power-up sequencing counts
    // ----------------------------------------------------------------
    localparam logic [2:0] BOOT_CATCH = 3'h4;
    localparam logic [2:0] BOOT_EVT = 3'h5;
    localparam logic [2:0] BOOT_DONE = 3'h6;

    typedef enum logic [2:0] {
        ST_READY,
        ST_RUN,
        ST_JOG,
        ST_INHIBIT,
        ST_TRIPPED
    } drs_state_t;

endpackage

// ### hdl/drs_sync.sv
// Three-flop input synchroniser with agreement filter for pin inputs.
`timescale 1ns/1ps
module drs_sync #(
    parameter int W = 1
) (
    input wire logic i_clk_sys, // System clock.
    input wire logic i_rst, // Asynchronous reset, active high.
    input wire logic [W-1:0] i_pin, // Raw pin levels.
    output logic [W-1:0] o_level // Filtered levels.
);
    import drs_pkg::*;

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] lvl;
    } drs_sync_st_t;

    drs_sync_st_t st_q;
    drs_sync_st_t st_d;

    // A change counts only once the second and third stages agree, so a
    // single-cycle glitch through the first stage never reaches the logic.
    always_comb begin
        st_d = st_q;
        st_d.s1 = i_pin;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        st_d.lvl = (st_q.s2 & ~(st_q.s2 ^ st_q.s3)) | (st_q.lvl & (st_q.s2 ^ st_q.s3));
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign o_level = st_q.lvl;
endmodule

// ### hdl/drs_autostart.sv
// Auto-start decision at power-up or undervoltage recovery.
`timescale 1ns/1ps
module drs_autostart (
    input wire logic i_clk_sys, // System clock.
    input wire logic i_rst, // Asynchronous reset, active high.
    input wire logic i_evt, // Power-up or recovery pulse.
    input wire logic [1:0] i_sel, // Auto-start selector.
    input wire logic [2:0] i_mode, // Sequencing mode.
    input wire logic i_keypad, // Keypad sequencing active.
    input wire logic i_drive_enable, // Drive enable bit.
    input wire logic i_was_running, // Retained running record.
    output logic o_start // One-cycle start pulse.
);
    import drs_pkg::*;

    typedef struct packed {
        logic start;
    } drs_as_st_t;

    drs_as_st_t st_q;
    drs_as_st_t st_d;
    logic mode_ok;
    logic sel_ok;

    always_comb begin
        st_d = st_q;
        mode_ok = ((i_mode == SEQ_MODE_PUSHBUTTON) || (i_mode == SEQ_MODE_LEGACY)) && !i_keypad;
        sel_ok = (i_sel == AUTOSTART_ALWAYS)
            || ((i_sel == AUTOSTART_POWERDOWN_DEPENDENT) && i_was_running);
        st_d.start = i_evt && mode_ok && sel_ok && i_drive_enable;
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign o_start = st_q.start;
endmodule

// ### hdl/drs_seq_top.sv
// Drive run sequencer top: APB registers, input conditioning and run/jog/stop state machine.
`timescale 1ns/1ps
module drs_seq_top (
    input wire logic i_clk_sys, // System clock, 20 MHz.
    input wire logic i_rst, // Asynchronous reset, active high.
    input wire logic i_psel, // APB select.
    input wire logic i_penable, // APB enable.
    input wire logic i_pwrite, // APB write.
    input wire logic [7:0] i_paddr, // APB byte address.
    input wire logic [31:0] i_pwdata, // APB write data.
    output logic [31:0] o_prdata, // APB read data.
    output logic o_pready, // APB ready.
    output logic o_pslverr, // APB error.
    input wire logic [4:0] i_term, // Terminal sequencing bits and drive enable.
    input wire logic i_key_run, // Keypad run key.
    input wire logic i_key_stop, // Keypad stop/reset key.
    input wire logic i_key_dir, // Keypad forward/reverse key.
    input wire logic i_trip, // Trip condition present.
    input wire logic i_uv_recover, // High once supply is healthy again.
    input wire logic i_nv_was_running, // Retained running record read back.
    output logic o_nv_was_running, // Running record to retained storage.
    output logic o_run, // Drive running.
    output logic o_jog, // Drive jogging.
    output logic o_reverse, // Direction is reverse.
    output logic o_tripped, // Tripped state.
    output logic [2:0] o_state // Sequencer state code.
);
    import drs_pkg::*;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [1:0] auto_sel;
        logic [2:0] mode;
        logic key_run_en;
        logic key_stop_en;
        logic key_dir_en;
        logic out_en;
        logic [2:0] kp_ref;
        logic [4:0] serial;
        logic [4:0] assign_mask;
        drs_state_t state;
        logic dir_tog;
        logic rev;
        logic stop_prev;
        logic dir_prev;
        logic uv_prev;
        logic [2:0] boot;
        logic rec;
        logic [31:0] prdata;
        logic pslverr;
    } drs_top_st_t;

    drs_top_st_t st_q;
    drs_top_st_t st_d;

    logic [10:0] pin_raw;
    logic [10:0] pin_lvl;
    logic [4:0] term;
    logic key_run;
    logic key_stop;
    logic key_dir;
    logic trip;
    logic uv_ok;
    logic nv_rec;
    logic [4:0] seq;
    logic keypad;
    logic pushbutton;
    logic run_req;
    logic jog_req;
    logic stop_req;
    logic permit;
    logic dir_sel;
    logic stop_rise;
    logic dir_rise;
    logic evt;
    logic auto_start;
    logic wr_en;
    logic rd_setup;
    logic [31:0] rd_val;
    logic rd_hit;

    // ----------------------------------------------------------------
    // Input conditioning
    // ----------------------------------------------------------------
    assign pin_raw = {i_nv_was_running, i_uv_recover, i_trip, i_key_dir, i_key_stop, i_key_run, i_term};

    drs_sync #(
        .W(11)
    ) u_sync (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_pin(pin_raw),
        .o_level(pin_lvl)
    );

    assign term = pin_lvl[4:0];
    assign key_run = pin_lvl[5];
    assign key_stop = pin_lvl[6];
    assign key_dir = pin_lvl[7];
    assign trip = pin_lvl[8];
    assign uv_ok = pin_lvl[9];
    assign nv_rec = pin_lvl[10];

    // Each bit is taken from its terminal when assigned, else from the serial copy.
    assign seq = (st_q.assign_mask & term) | (~st_q.assign_mask & st_q.serial);

    assign stop_rise = key_stop && !st_q.stop_prev;
    assign dir_rise = key_dir && !st_q.dir_prev;
    assign keypad = (st_q.kp_ref == KEYPAD_REF_SEL);
    assign pushbutton = (st_q.mode == SEQ_MODE_PUSHBUTTON) && !keypad;

    // Power-up counts as one event once the synchronisers hold valid levels;
    // a rising healthy-supply level counts as undervoltage recovery.
    assign evt = (st_q.boot == BOOT_EVT) || (uv_ok && !st_q.uv_prev && st_q.boot == BOOT_DONE);

    drs_autostart u_autostart (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_evt(evt),
        .i_sel(st_q.auto_sel),
        .i_mode(st_q.mode),
        .i_keypad(keypad),
        .i_drive_enable(seq[SEQ_BIT_DRIVE_EN]),
        .i_was_running(st_q.rec),
        .o_start(auto_start)
    );

    // ----------------------------------------------------------------
    // Request decode per sequencing mode
    // ----------------------------------------------------------------
    always_comb begin
        run_req = 1'b0;
        jog_req = 1'b0;
        stop_req = 1'b0;
        dir_sel = st_q.rev;
        permit = seq[SEQ_BIT_DRIVE_EN];
        if (keypad) begin
            run_req = key_run;
            stop_req = stop_rise;
            dir_sel = st_q.dir_tog;
        end else if (pushbutton) begin
            run_req = st_q.key_run_en ? key_run : seq[SEQ_BIT_RUN];
            jog_req = seq[SEQ_BIT_JOG];
            dir_sel = st_q.key_dir_en ? st_q.dir_tog : seq[SEQ_BIT_DIR];
            stop_req = st_q.key_stop_en && stop_rise;
        end
    end

    // ----------------------------------------------------------------
    // APB access
    // ----------------------------------------------------------------
    // Zero wait states: read data and error are registered in the setup
    // cycle so they are stable throughout the access cycle.
    assign wr_en = i_psel && i_penable && i_pwrite;
    assign rd_setup = i_psel && !i_penable;

    always_comb begin
        rd_val = 32'h0000_0000;
        rd_hit = 1'b1;
        if (i_paddr == ADDR_AUTO_START) begin
            rd_val[1:0] = st_q.auto_sel;
        end else if (i_paddr == ADDR_SEQ_MODE) begin
            rd_val[2:0] = st_q.mode;
        end else if (i_paddr == ADDR_CONFIG) begin
            rd_val[CFG_KEY_RUN_EN] = st_q.key_run_en;
            rd_val[CFG_KEY_STOP_EN] = st_q.key_stop_en;
            rd_val[CFG_KEY_DIR_EN] = st_q.key_dir_en;
            rd_val[CFG_OUT_STAGE_EN] = st_q.out_en;
            rd_val[CFG_KP_REF_LSB +: 3] = st_q.kp_ref;
        end else if (i_paddr == ADDR_SEQ_SERIAL) begin
            rd_val[4:0] = st_q.serial;
        end else if (i_paddr == ADDR_TERM_ASSIGN) begin
            rd_val[4:0] = st_q.assign_mask;
        end else if (i_paddr == ADDR_STATUS) begin
            rd_val[2:0] = st_q.state;
            rd_val[ST_REV_POS] = st_q.rev;
            rd_val[ST_REC_POS] = st_q.rec;
            rd_val[ST_TRIP_POS] = (st_q.state == ST_TRIPPED);
        end else begin
            rd_hit = 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        st_d.stop_prev = key_stop;
        st_d.dir_prev = key_dir;
        st_d.uv_prev = uv_ok;
        if (st_q.boot != BOOT_DONE) begin
            st_d.boot = st_q.boot + 3'h1;
        end

        if (rd_setup) begin
            st_d.prdata = rd_val;
            st_d.pslverr = !rd_hit;
        end

        if (wr_en) begin
            if (i_paddr == ADDR_AUTO_START) begin
                if (i_pwdata[1:0] <= AUTOSTART_POWERDOWN_DEPENDENT) begin
                    st_d.auto_sel = i_pwdata[1:0];
                end
            end else if (i_paddr == ADDR_SEQ_MODE) begin
                if (i_pwdata[2:0] <= SEQ_MODE_MAX && i_pwdata[31:3] == 29'h0) begin
                    st_d.mode = i_pwdata[2:0];
                end
            end else if (i_paddr == ADDR_CONFIG) begin
                st_d.key_run_en = i_pwdata[CFG_KEY_RUN_EN];
                st_d.key_stop_en = i_pwdata[CFG_KEY_STOP_EN];
                st_d.key_dir_en = i_pwdata[CFG_KEY_DIR_EN];
                st_d.out_en = i_pwdata[CFG_OUT_STAGE_EN];
                st_d.kp_ref = i_pwdata[CFG_KP_REF_LSB +: 3];
            end else if (i_paddr == ADDR_SEQ_SERIAL) begin
                st_d.serial = i_pwdata[4:0];
            end else if (i_paddr == ADDR_TERM_ASSIGN) begin
                st_d.assign_mask = i_pwdata[4:0];
            end
        end

        // The keypad direction key toggles a stored direction on each press in keypad sequencing, or in pushbutton mode with key_dir_en set.
        if (dir_rise && (keypad || (pushbutton && st_q.key_dir_en))) begin
            st_d.dir_tog = !st_q.dir_tog;
        end

        if (trip) begin
            st_d.state = ST_TRIPPED;
        end else if (!st_q.out_en) begin
            st_d.state = ST_INHIBIT;
        end else begin
            case (st_q.state)
                ST_TRIPPED, ST_INHIBIT: begin
                    st_d.state = ST_READY;
                end
                ST_READY: begin
                    if (permit && (run_req || auto_start)) begin
                        st_d.state = ST_RUN;
                    end else if (permit && jog_req) begin
                        st_d.state = ST_JOG;
                    end
                end
                ST_RUN: begin
                    if (!permit || stop_req) begin
                        st_d.state = ST_READY;
                    end
                end
                ST_JOG: begin
                    if (!permit || !jog_req) begin
                        st_d.state = ST_READY;
                    end else if (run_req) begin
                        st_d.state = ST_RUN;
                    end
                end
                default: begin
                    st_d.state = ST_READY;
                end
            endcase
        end

        if (st_d.state == ST_RUN || st_d.state == ST_JOG) begin
            st_d.rev = dir_sel;
        end

        // The record is frozen while tripped or inhibited so that an
        // undervoltage trip keeps what the drive was doing at supply loss.
        if (st_q.boot == BOOT_CATCH) begin
            st_d.rec = nv_rec;
        end else if (st_q.boot == BOOT_DONE && st_q.state != ST_TRIPPED && st_q.state != ST_INHIBIT) begin
            st_d.rec = (st_q.state == ST_RUN);
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            st_q <= '0;
            st_q.auto_sel <= AUTO_START_RESET;
            st_q.mode <= SEQ_MODE_RESET;
            st_q.out_en <= OUT_STAGE_EN_RESET;
            st_q.kp_ref <= KEYPAD_REF_RESET;
            st_q.serial <= SEQ_SERIAL_RESET;
            st_q.assign_mask <= TERM_ASSIGN_RESET;
            st_q.state <= ST_INHIBIT;
        end else begin
            st_q <= st_d;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign o_pready = 1'b1;
    assign o_prdata = st_q.prdata;
    assign o_pslverr = st_q.pslverr;
    assign o_nv_was_running = st_q.rec;
    assign o_run = (st_q.state == ST_RUN);
    assign o_jog = (st_q.state == ST_JOG);
    assign o_reverse = st_q.rev;
    assign o_tripped = (st_q.state == ST_TRIPPED);
    assign o_state = st_q.state;
endmodule

// ### tb/drs_panel_model.sv
// Behavioural model of the input terminals, keypad keys, trip and supply pins.
`timescale 1ns/1ps
module drs_panel_model (
    input wire logic i_clk_sys, // System clock.
    output logic [4:0] o_term, // Terminal levels.
    output logic o_key_run, // Run key.
    output logic o_key_stop, // Stop/reset key.
    output logic o_key_dir, // Forward/reverse key.
    output logic o_trip, // Trip condition.
    output logic o_uv_ok // Supply healthy.
);
    initial begin
        {o_uv_ok, o_trip, o_key_dir, o_key_stop, o_key_run, o_term} = 10'h200;
    end

    // Pins are levels, so each setting is held long enough to pass the input filter.
    task automatic drive(input logic [9:0] v);
        @(posedge i_clk_sys);
        {o_uv_ok, o_trip, o_key_dir, o_key_stop, o_key_run, o_term} <= v;
        repeat (8) @(posedge i_clk_sys);
    endtask
endmodule

// ### tb/drs_seq_checker.sv
// Concurrent assertions on the run sequencer top ports.
`timescale 1ns/1ps
module drs_seq_checker
    import drs_pkg::*;
(
    input wire logic i_clk_sys, // Clock.
    input wire logic i_rst, // Reset.
    input wire logic i_psel, // Select.
    input wire logic i_penable, // Enable.
    input wire logic [7:0] i_paddr, // Address.
    input wire logic o_pready, // Ready.
    input wire logic o_pslverr, // Error.
    input wire logic i_trip, // Trip pin.
    input wire logic o_nv_was_running, // Record.
    input wire logic o_run, // Running.
    input wire logic o_jog, // Jogging.
    input wire logic o_tripped, // Tripped.
    input wire logic [2:0] o_state // State.
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);

    chk_ready_high: assert property (o_pready) else $error("pready low");
    chk_bad_addr: assert property (i_psel && !i_penable && (i_paddr > ADDR_STATUS || i_paddr[1:0] != 2'h0)
        |=> o_pslverr) else $error("no error on unmapped address");
    chk_good_addr: assert property (i_psel && !i_penable && i_paddr <= ADDR_STATUS && i_paddr[1:0] == 2'h0
        |=> !o_pslverr) else $error("error on mapped address");
    chk_trip_seen: assert property (i_trip [*8] |-> o_state == ST_TRIPPED)
        else $error("trip not taken");
    chk_trip_exit: assert property (o_state == ST_TRIPPED |=> o_state inside {ST_TRIPPED, ST_READY})
        else $error("bad exit from tripped");
    chk_inhibit_exit: assert property (o_state == ST_INHIBIT |=> o_state inside {ST_INHIBIT, ST_TRIPPED, ST_READY})
        else $error("bad exit from inhibit");
    chk_jog_entry: assert property ($rose(o_jog) |-> $past(o_state) == ST_READY)
        else $error("jog entered outside ready");
    chk_run_entry: assert property ($rose(o_run) |-> $past(o_state) inside {ST_READY, ST_JOG})
        else $error("run entered from bad state");
    chk_trip_flag: assert property (o_tripped == (o_state == ST_TRIPPED))
        else $error("tripped flag mismatch");
    chk_run_record: assert property (o_state == ST_RUN |=> o_nv_was_running)
        else $error("running record not set");

    cover property ($rose(o_run));
    cover property ($rose(o_jog));
    cover property ($rose(o_tripped));
endmodule

// ### tb/test_drive_run_sequencer.sv
// Self-checking testbench of the drive run sequencer.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin err_total++; \
    $display("ERROR %s exp %0h got %0h", nm, e, g); end end
module test_drive_run_sequencer;
    import drs_pkg::*;
    localparam logic [9:0] UV = 10'h200;
    localparam logic [9:0] TRIP = 10'h100;
    localparam logic [9:0] KSTOP = 10'h040;
    localparam logic [9:0] KRUN = 10'h020;
    logic i_clk_sys, i_rst, i_psel, i_penable, i_pwrite;
    logic [7:0] i_paddr;
    logic [31:0] i_pwdata, o_prdata, rdata;
    logic o_pready, o_pslverr, rerr;
    logic [4:0] i_term;
    logic i_key_run, i_key_stop, i_key_dir, i_trip, i_uv_recover;
    logic o_nv_was_running, o_run, o_jog, o_reverse, o_tripped;
    logic [2:0] o_state;
    logic [2:0] tm [5] = '{3'h0, 3'h0, 3'h2, 3'h1, 3'h0};
    logic [1:0] ta [5] = '{2'h2, 2'h0, 2'h1, 2'h1, 2'h1};
    logic [2:0] te [5] = '{ST_READY, ST_READY, ST_READY, ST_RUN, ST_RUN};
    int err_total = 0;
    int n_checks = 0;

    drs_seq_top DUT (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable),
        .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
        .o_pready(o_pready), .o_pslverr(o_pslverr), .i_term(i_term), .i_key_run(i_key_run),
        .i_key_stop(i_key_stop), .i_key_dir(i_key_dir), .i_trip(i_trip), .i_uv_recover(i_uv_recover),
        .i_nv_was_running(1'b0), .o_nv_was_running(o_nv_was_running), .o_run(o_run), .o_jog(o_jog),
        .o_reverse(o_reverse), .o_tripped(o_tripped), .o_state(o_state));
    drs_panel_model panel (.i_clk_sys(i_clk_sys), .o_term(i_term), .o_key_run(i_key_run),
        .o_key_stop(i_key_stop), .o_key_dir(i_key_dir), .o_trip(i_trip), .o_uv_ok(i_uv_recover));

    initial begin
        i_clk_sys = 1'b0;
        forever #25 i_clk_sys = ~i_clk_sys;
    end

    task automatic give_verdict;
        if (err_total == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk_sys);
        i_psel <= 1'b1;
        i_penable <= 1'b0;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_clk_sys);
        i_penable <= 1'b1;
        do @(posedge i_clk_sys); while (o_pready !== 1'b1);
        rdata = o_prdata;
        rerr = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string nm);
        apb(1'b0, a, 32'h0);
        `CHK(nm, e, rdata)
    endtask

    // The filtered pins settle within about five cycles, so twelve leaves margin.
    task automatic st(input logic [2:0] e, input string nm);
        repeat (12) @(posedge i_clk_sys);
        `CHK(nm, e, o_state)
    endtask

    initial begin
        repeat (20000) @(posedge i_clk_sys);
        err_total++;
        give_verdict;
    end

    initial begin
        i_rst = 1'b1;
        i_psel = 1'b0;
        i_penable = 1'b0;
        i_pwrite = 1'b0;
        i_paddr = 8'h00;
        i_pwdata = 32'h0;
        repeat (5) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        st(ST_READY, "boot");
        rchk(ADDR_AUTO_START, 32'h0, "auto rst");
        rchk(ADDR_SEQ_MODE, 32'h2, "mode rst");
        rchk(ADDR_CONFIG, 32'h8, "cfg rst");
        rchk(8'h18, 32'h0, "unmapped");
        `CHK("slverr", 1'b1, rerr)
        for (int i = 0; i < 3; i++) begin
            wr(ADDR_AUTO_START, 32'(i));
            rchk(ADDR_AUTO_START, 32'(i), "auto");
        end
        wr(ADDR_AUTO_START, 32'h3);
        rchk(ADDR_AUTO_START, 32'h2, "auto bad");
        for (int i = 0; i < 5; i++) begin
            wr(ADDR_SEQ_MODE, 32'(i));
            rchk(ADDR_SEQ_MODE, 32'(i), "mode");
        end
        wr(ADDR_SEQ_MODE, 32'h5);
        rchk(ADDR_SEQ_MODE, 32'h4, "mode bad");
        wr(ADDR_SEQ_SERIAL, 32'h10);
        for (int i = 0; i < 5; i++) begin
            wr(ADDR_SEQ_MODE, 32'(tm[i]));
            wr(ADDR_AUTO_START, 32'(ta[i]));
            panel.drive(10'h000);
            panel.drive(UV);
            st(te[i], "auto start");
            wr(ADDR_SEQ_SERIAL, 32'h00);
            st(ST_READY, "enable off");
            wr(ADDR_SEQ_SERIAL, 32'h10);
        end
        // A trip with the supply down freezes the running record, so the recovery restarts the drive.
        wr(ADDR_AUTO_START, 32'h2);
        wr(ADDR_SEQ_SERIAL, 32'h11);
        wr(ADDR_SEQ_SERIAL, 32'h10);
        panel.drive(TRIP);
        panel.drive(UV);
        st(ST_RUN, "pd restart");
        wr(ADDR_SEQ_SERIAL, 32'h00);
        wr(ADDR_AUTO_START, 32'h0);
        wr(ADDR_SEQ_SERIAL, 32'h11);
        st(ST_RUN, "run");
        `CHK("run flag", 1'b1, o_run)
        wr(ADDR_SEQ_SERIAL, 32'h10);
        st(ST_RUN, "latch");
        `CHK("record", 1'b1, o_nv_was_running)
        rchk(ADDR_STATUS, 32'h21, "status");
        wr(ADDR_SEQ_SERIAL, 32'h16);
        st(ST_RUN, "jog in run");
        `CHK("reverse", 1'b1, o_reverse)
        wr(ADDR_SEQ_SERIAL, 32'h00);
        st(ST_READY, "stop");
        wr(ADDR_SEQ_SERIAL, 32'h12);
        st(ST_JOG, "jog");
        `CHK("jog flag", 1'b1, o_jog)
        wr(ADDR_CONFIG, 32'h0a);
        panel.drive(UV | KSTOP);
        panel.drive(UV);
        st(ST_JOG, "stop in jog");
        wr(ADDR_SEQ_SERIAL, 32'h10);
        st(ST_READY, "jog end");
        wr(ADDR_SEQ_SERIAL, 32'h13);
        st(ST_RUN, "run over jog");
        wr(ADDR_SEQ_SERIAL, 32'h10);
        panel.drive(UV | KSTOP);
        panel.drive(UV);
        st(ST_READY, "stop key");
        wr(ADDR_CONFIG, 32'h0b);
        panel.drive(UV | KRUN);
        panel.drive(UV);
        st(ST_RUN, "run key");
        wr(ADDR_CONFIG, 32'h03);
        st(ST_INHIBIT, "inhibit");
        `CHK("inhibit run", 1'b0, o_run)
        wr(ADDR_CONFIG, 32'h0b);
        st(ST_READY, "uninhibit");
        panel.drive(UV | TRIP);
        wr(ADDR_SEQ_SERIAL, 32'h11);
        st(ST_TRIPPED, "trip");
        `CHK("trip flag", 1'b1, o_tripped)
        wr(ADDR_SEQ_SERIAL, 32'h10);
        panel.drive(UV);
        st(ST_READY, "untrip");
        wr(ADDR_CONFIG, 32'h08);
        wr(ADDR_TERM_ASSIGN, 32'h01);
        panel.drive(UV | 10'h001);
        panel.drive(UV);
        st(ST_RUN, "term run");
        wr(ADDR_TERM_ASSIGN, 32'h11);
        st(ST_READY, "term enable");
        wr(ADDR_TERM_ASSIGN, 32'h00);
        wr(ADDR_SEQ_MODE, 32'h2);
        wr(ADDR_CONFIG, 32'h4b);
        panel.drive(UV | KRUN);
        panel.drive(UV);
        st(ST_RUN, "keypad run");
        panel.drive(UV | KSTOP);
        panel.drive(UV);
        st(ST_READY, "keypad stop");
        give_verdict;
    end
endmodule

bind drs_seq_top drs_seq_checker u_chk (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_psel(i_psel),
    .i_penable(i_penable), .i_paddr(i_paddr), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .i_trip(i_trip), .o_nv_was_running(o_nv_was_running), .o_run(o_run), .o_jog(o_jog),
    .o_tripped(o_tripped), .o_state(o_state));
